//--- hw/transmit_list_status_handler.sv
// Function
// - no list processing starts until ready bit 0 reads one; keep waiting (code checks it on a frame's start list only)
// - bit 4 set means interrupt right after that frame is transmitted
// - per-frame interrupt bit ignored when frame start bit 2 is zero
// - completion code written only to the frame's starting list
// - status word of a non-starting list is never changed
// - completion clears bit 0, sets bit 1, copies bits 2-4 and 6-7
// - completion bit 5 set on transmit or strip failure, else cleared
// - completion bits 8-15 hold the stripped frame status byte
`timescale 1ns/1ps
`include "xmit_status_defs.svh"
module transmit_list_status_handler (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // list fetch side: one list status word offered per handshake
  input  wire logic        list_valid,
  input  wire logic [15:0] list_status_word,
  input  wire logic        list_last,
  output logic             list_accept,
  output logic             list_hold,
  // frame handed to the transmitter
  output logic             frame_go,
  // transmitter completion report
  input  wire logic        frame_done,
  input  wire logic        frame_error,
  input  wire logic [7:0]  frame_status_byte,
  // status write-back
  output logic             wb_valid,
  output logic      [15:0] wb_word,
  output logic             irq
);
  typedef struct packed {
    xmit_status_pkg::walk_state_t st;
    logic                         expect_start;
    logic                         frame_irq;
    logic                         chain_end;
    logic [15:0]                  start_word;
    logic                         enable;
    logic [`IRQ_WIDTH-1:0]        irq_stat;
    logic [`IRQ_WIDTH-1:0]        irq_en;
    logic [15:0]                  last_word;
    logic [15:0]                  frames;
    logic                         dp_read;
    logic                         dp_write;
    logic [11:0]                  dp_addr;
    logic [31:0]                  rdata;
    logic                         accept;
    logic                         hold;
    logic                         go;
    logic                         wb_v;
    logic [15:0]                  wb_w;
    logic                         irq_o;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [15:0] done_word;
  logic [`IRQ_WIDTH-1:0] clr;
  logic [`IRQ_WIDTH-1:0] ev;
  logic take;
  logic [31:0] rd;

  completion_word u_done (
    .request_word      (s_reg.start_word),
    .frame_error       (frame_error),
    .frame_status_byte (frame_status_byte),
    .done_word         (done_word)
  );

  function automatic logic [31:0] pad16(input logic [15:0] v);
    pad16 = {16'h0000, v};
  endfunction

  // word-aligned register match, byte lanes ignored
  function automatic logic word_hit(input logic [11:0] a, input logic [11:0] ofs);
    word_hit = (a[11:2] == ofs[11:2]);
  endfunction

  always_comb begin
    s_next = s_reg;
    clr = '0;
    ev = '0;
    rd = 32'h0000_0000;
    s_next.accept = 1'b0;
    s_next.go = 1'b0;
    s_next.wb_v = 1'b0;
    take = 1'b0;
    // bus data phase
    s_next.dp_read = 1'b0;
    s_next.dp_write = 1'b0;
    if (s_reg.dp_write) begin
      if (word_hit(s_reg.dp_addr, `REG_CTRL_OFS)) begin
        s_next.enable = hwdata[`CTRL_ENABLE_BIT];
      end else if (word_hit(s_reg.dp_addr, `REG_IRQ_EN_OFS)) begin
        s_next.irq_en = hwdata[`IRQ_WIDTH-1:0];
      end else if (word_hit(s_reg.dp_addr, `REG_IRQ_CLR_OFS)) begin
        clr = hwdata[`IRQ_WIDTH-1:0];
      end
    end
    if (hsel && hready && htrans[1]) begin
      s_next.dp_read = !hwrite;
      s_next.dp_write = hwrite;
      s_next.dp_addr = {haddr[11:2], 2'b00};
      if (word_hit(haddr, `REG_CTRL_OFS)) begin
        rd = {30'h0, 1'b0, s_reg.enable};
      end else if (word_hit(haddr, `REG_STATE_OFS)) begin
        rd = {28'h0, s_reg.hold, s_reg.expect_start, 2'(s_reg.st)};
      end else if (word_hit(haddr, `REG_IRQ_STAT_OFS)) begin
        rd = {29'h0, s_reg.irq_stat};
      end else if (word_hit(haddr, `REG_IRQ_EN_OFS)) begin
        rd = {29'h0, s_reg.irq_en};
      end else if (word_hit(haddr, `REG_LAST_WORD_OFS)) begin
        rd = pad16(s_reg.last_word);
      end else if (word_hit(haddr, `REG_FRAMES_OFS)) begin
        rd = pad16(s_reg.frames);
      end
      s_next.rdata = rd;
    end
    // list walk
    case (s_reg.st)
      xmit_status_pkg::st_idle: begin
        s_next.hold = 1'b0;
        if (s_reg.enable) begin
          s_next.st = xmit_status_pkg::st_wait_ready;
          s_next.expect_start = 1'b1;
        end
      end
      xmit_status_pkg::st_wait_ready: begin
        // only a list expected to start a frame waits on ready
        s_next.hold = list_valid && !list_status_word[`LSW_READY_BIT];
        if (!s_reg.enable) begin
          s_next.st = xmit_status_pkg::st_idle;
        end else if (list_valid && !s_reg.accept &&
                     list_status_word[`LSW_READY_BIT]) begin
          take = 1'b1;
          s_next.start_word = list_status_word;
          // frame interrupt only counts with the start bit
          s_next.frame_irq = list_status_word[`LSW_FRAME_IRQ_BIT] &
                             list_status_word[`LSW_START_BIT];
          s_next.chain_end = list_last;
          s_next.expect_start = 1'b0;
          s_next.hold = 1'b0;
          s_next.go = 1'b1;
          s_next.st = list_status_word[`LSW_END_BIT] ? xmit_status_pkg::st_wait_done
                                                     : xmit_status_pkg::st_in_frame;
        end
      end
      xmit_status_pkg::st_in_frame: begin
        // continuation lists: ready flag not looked at
        if (list_valid && !s_reg.accept) begin
          take = 1'b1;
          s_next.chain_end = list_last;
          if (list_status_word[`LSW_END_BIT]) begin
            s_next.st = xmit_status_pkg::st_wait_done;
          end
        end
      end
      xmit_status_pkg::st_wait_done: begin
        if (frame_done) begin
          // write back to the start list only; others untouched
          s_next.wb_v = 1'b1;
          s_next.wb_w = done_word;
          s_next.last_word = done_word;
          s_next.frames = s_reg.frames + 16'h0001;
          ev[`IRQ_FRAME_BIT] = s_reg.frame_irq;
          ev[`IRQ_CHAIN_BIT] = s_reg.chain_end;
          ev[`IRQ_ERROR_BIT] = frame_error;
          s_next.expect_start = 1'b1;
          s_next.st = s_reg.chain_end ? xmit_status_pkg::st_idle
                                      : xmit_status_pkg::st_wait_ready;
          if (s_reg.chain_end) begin
            s_next.enable = 1'b0;
          end
        end
      end
      default: s_next.st = xmit_status_pkg::st_idle;
    endcase
    s_next.accept = take;
    // set wins over clear
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq_o = |(s_next.irq_stat & s_next.irq_en);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign list_accept = s_reg.accept;
  assign list_hold = s_reg.hold;
  assign frame_go = s_reg.go;
  assign wb_valid = s_reg.wb_v;
  assign wb_word = s_reg.wb_w;
  assign irq = s_reg.irq_o;

  a_no_start_unready: assert property (@(posedge core_clk) disable iff (reset)
    frame_go |-> $past(list_status_word[`LSW_READY_BIT]))
    else $error("frame started on unready list");
  a_wb_clears_ready: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |-> !wb_word[`LSW_READY_BIT] && wb_word[`LSW_COMPLETE_BIT])
    else $error("completion word ready/complete wrong");
  a_wb_copies_bits: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |-> wb_word[4:2] == s_reg.start_word[4:2]
                 && wb_word[7:6] == s_reg.start_word[7:6])
    else $error("completion word copy bits wrong");
  a_wb_error_bit: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |-> wb_word[`LSW_ERROR_BIT] == $past(frame_error))
    else $error("error bit mismatch");
  a_wb_fs_byte: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |-> wb_word[15:8] == $past(frame_status_byte))
    else $error("frame status byte mismatch");
  a_wb_after_done: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |-> $past(frame_done) && $past(s_reg.st) == xmit_status_pkg::st_wait_done)
    else $error("write-back without completed frame");
  a_one_wb_frame: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid |=> !wb_valid)
    else $error("repeated write-back");
  a_frame_irq_gate: assert property (@(posedge core_clk) disable iff (reset)
    frame_go |=> s_reg.frame_irq == (s_reg.start_word[4] & s_reg.start_word[2]))
    else $error("frame interrupt not gated by start");
  a_frame_irq_set: assert property (@(posedge core_clk) disable iff (reset)
    wb_valid && s_reg.frame_irq |-> s_reg.irq_stat[`IRQ_FRAME_BIT])
    else $error("frame interrupt not raised");
  a_cont_no_ready: assert property (@(posedge core_clk) disable iff (reset)
    s_reg.st == xmit_status_pkg::st_in_frame && list_valid && !list_accept
    |=> list_accept)
    else $error("continuation list stalled");
  c_frame: cover property (@(posedge core_clk) disable iff (reset) wb_valid);
  c_err: cover property (@(posedge core_clk) disable iff (reset) wb_valid && wb_word[5]);
  c_irq: cover property (@(posedge core_clk) disable iff (reset) $rose(irq));
  c_hold: cover property (@(posedge core_clk) disable iff (reset) list_hold ##1 frame_go);
endmodule

//--- hw/xmit_status_defs.svh
`ifndef XMIT_STATUS_DEFS_SVH
`define XMIT_STATUS_DEFS_SVH
// list status word fields
`define LSW_READY_BIT      0
`define LSW_COMPLETE_BIT   1
`define LSW_START_BIT      2
`define LSW_END_BIT        3
`define LSW_FRAME_IRQ_BIT  4
`define LSW_ERROR_BIT      5
`define LSW_RSVD_LO        6
`define LSW_RSVD_HI        7
`define LSW_FSB_LO         8
`define LSW_FSB_HI         15
// register byte offsets
`define REG_CTRL_OFS       12'h000
`define REG_STATE_OFS      12'h004
`define REG_IRQ_STAT_OFS   12'h008
`define REG_IRQ_EN_OFS     12'h00c
`define REG_IRQ_CLR_OFS    12'h010
`define REG_LAST_WORD_OFS  12'h014
`define REG_FRAMES_OFS     12'h018
// control register bits
`define CTRL_ENABLE_BIT    0
`define CTRL_RESUME_BIT    1
// interrupt status bits
`define IRQ_FRAME_BIT      0
`define IRQ_CHAIN_BIT      1
`define IRQ_ERROR_BIT      2
`define IRQ_WIDTH          3
`endif

//--- hw/xmit_status_pkg.sv
package xmit_status_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_wait_ready,
    st_in_frame,
    st_wait_done
  } walk_state_t;
endpackage

//--- hw/completion_word.sv
`timescale 1ns/1ps
`include "xmit_status_defs.svh"
module completion_word (
  input  wire logic [15:0] request_word,
  input  wire logic        frame_error,
  input  wire logic [7:0]  frame_status_byte,
  output logic      [15:0] done_word
);
  always_comb begin
    done_word = request_word;
    done_word[`LSW_READY_BIT]    = 1'b0;
    done_word[`LSW_COMPLETE_BIT] = 1'b1;
    done_word[`LSW_ERROR_BIT]    = frame_error;
    done_word[`LSW_FSB_HI:`LSW_FSB_LO] = frame_status_byte;
  end
endmodule

//--- bench/list_host_model.sv
`timescale 1ns/1ps
module list_host_model (
  input  wire logic        core_clk,
  input  wire logic        list_accept,
  output logic             list_valid,
  output logic      [15:0] list_status_word,
  output logic             list_last,
  output logic             frame_done,
  output logic             frame_error,
  output logic      [7:0]  frame_status_byte
);
  logic [16:0] lists[$];
  logic        done_req;
  logic [8:0]  done_info;
  initial begin
    list_valid = 1'b0;
    list_status_word = 16'h0000;
    list_last = 1'b0;
    frame_done = 1'b0;
    frame_error = 1'b0;
    frame_status_byte = 8'h00;
    done_req = 1'b0;
    done_info = 9'h000;
  end
  // complete bit and reserved bits always built as zero; caller marks start/end
  task automatic build(input logic [15:0] w, input logic last);
    lists.push_back({last, w & 16'h001d});
  endtask
  // host sets the ready flag of the list at the head to one
  task automatic set_ready();
    lists[0][0] = 1'b1;
  endtask
  task automatic finish(input logic err, input logic [7:0] fs);
    done_info = {err, fs};
    done_req = 1'b1;
  endtask
  always @(posedge core_clk) begin
    if (list_accept === 1'b1 && lists.size() != 0)
      void'(lists.pop_front());
    list_valid <= (lists.size() != 0);
    if (lists.size() != 0) begin
      list_status_word <= lists[0][15:0];
      list_last <= lists[0][16];
    end else begin
      // nothing offered: lines toggle rather than hold a stale word
      list_status_word <= ~list_status_word;
      list_last <= ~list_last;
    end
    frame_done <= done_req;
    frame_error <= done_req ? done_info[8] : ~frame_error;
    frame_status_byte <= done_req ? done_info[7:0] : ~frame_status_byte;
    done_req = 1'b0;
  end
endmodule

//--- bench/transmit_list_status_handler_test.sv
`timescale 1ns/1ps
`include "xmit_status_defs.svh"
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module transmit_list_status_handler_test;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, list_valid, list_last, list_accept, list_hold;
  logic        frame_go, frame_done, frame_error, wb_valid, irq;
  logic [15:0] list_status_word, wb_word, last_wb;
  logic [7:0]  frame_status_byte;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_wb = 0;
  int          n_go = 0;
  always #10 core_clk = ~core_clk;
  transmit_list_status_handler i_transmit_list_status_handler (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .list_valid(list_valid),
    .list_status_word(list_status_word), .list_last(list_last), .list_accept(list_accept),
    .list_hold(list_hold), .frame_go(frame_go), .frame_done(frame_done),
    .frame_error(frame_error), .frame_status_byte(frame_status_byte),
    .wb_valid(wb_valid), .wb_word(wb_word), .irq(irq));
  list_host_model i_list_host_model (
    .core_clk(core_clk), .list_accept(list_accept), .list_valid(list_valid),
    .list_status_word(list_status_word), .list_last(list_last), .frame_done(frame_done),
    .frame_error(frame_error), .frame_status_byte(frame_status_byte));
  always @(posedge core_clk) begin
    if (wb_valid === 1'b1) begin
      n_wb++;
      last_wb = wb_word;
    end
    if (frame_go === 1'b1)
      n_go++;
  end
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHECK(hresp, 1'b0)
  endtask
  task automatic summarize();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
  initial begin
    logic [31:0] q;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0, q);
    `CHECK(q, 32'h0)
    bus(1'b1, `REG_IRQ_EN_OFS, 32'h7, q);
    bus(1'b1, `REG_CTRL_OFS, 32'h1, q);
    // start list not ready, continuation with ready zero behind it
    @(negedge core_clk);
    i_list_host_model.build(16'h0014, 1'b0);
    i_list_host_model.build(16'h0008, 1'b0);
    repeat (6) @(posedge core_clk);
    `CHECK(list_hold, 1'b1)
    `CHECK(n_go, 0)
    @(negedge core_clk);
    i_list_host_model.set_ready();
    repeat (8) @(posedge core_clk);
    `CHECK(n_go, 1)
    `CHECK(list_valid, 1'b0)
    `CHECK(n_wb, 0)
    @(negedge core_clk);
    i_list_host_model.finish(1'b0, 8'ha5);
    repeat (4) @(posedge core_clk);
    `CHECK(n_wb, 1)
    `CHECK(last_wb, 16'ha516)
    `CHECK(irq, 1'b1)
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0, q);
    `CHECK(q[2:0], 3'b001)
    bus(1'b1, `REG_IRQ_CLR_OFS, 32'h1, q);
    repeat (2) @(posedge core_clk);
    `CHECK(irq, 1'b0)
    $display("test ready_wait done");
    // frame irq bit only on the continuation list, failed transmit, last in chain
    @(negedge core_clk);
    i_list_host_model.build(16'h0005, 1'b0);
    i_list_host_model.build(16'h0018, 1'b1);
    repeat (8) @(posedge core_clk);
    `CHECK(n_go, 2)
    @(negedge core_clk);
    i_list_host_model.finish(1'b1, 8'h3c);
    repeat (4) @(posedge core_clk);
    `CHECK(n_wb, 2)
    `CHECK(last_wb, 16'h3c26)
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0, q);
    `CHECK(q[2:0], 3'b110)
    bus(1'b0, 12'hffc, 32'h0, q);
    `CHECK(q, 32'h0)
    bus(1'b0, `REG_STATE_OFS, 32'h0, q);
    `CHECK(q, 32'h4)
    bus(1'b0, `REG_CTRL_OFS, 32'h0, q);
    `CHECK(q, 32'h0)
    $display("test error_frame done");
    // ready start list lacking the start bit: its frame irq bit must not count
    bus(1'b1, `REG_IRQ_CLR_OFS, 32'h7, q);
    bus(1'b1, `REG_CTRL_OFS, 32'h1, q);
    @(negedge core_clk);
    i_list_host_model.build(16'h0019, 1'b1);
    repeat (8) @(posedge core_clk);
    `CHECK(n_go, 3)
    @(negedge core_clk);
    i_list_host_model.finish(1'b0, 8'h5a);
    repeat (4) @(posedge core_clk);
    `CHECK(n_wb, 3)
    `CHECK(last_wb, 16'h5a1a)
    bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0, q);
    `CHECK(q[2:0], 3'b010)
    bus(1'b0, `REG_FRAMES_OFS, 32'h0, q);
    `CHECK(q, 32'h3)
    bus(1'b0, `REG_LAST_WORD_OFS, 32'h0, q);
    `CHECK(q, 32'h5a1a)
    $display("test start_bit_gate done");
    summarize();
  end
endmodule
